//--- rtl/rsc_pkg.sv
// package: constants and types for the regulator supervisor control block
//
// Contract
// - status bit follows detector continuously while the detector is active.
// - status set below assert threshold, cleared only above deassert threshold.
// - change flag sets on each status transition, both directions.
// - interrupt requested while change flag and enable are both one.
// - detector active only in full performance mode.
// - entering reduced power mode leaves the change flag untouched; the code sets it if status was one at entry, as status drops to zero.
// - power-on reset high while core supply below threshold, low above.
// - power-on reset supervision active in every regulator mode.
// - low-voltage reset asserts below assert level, negates above deassert.
// - low-voltage reset enabled only in full performance mode.
// - amplifier and bandgap disabled in reduced power, enabled in full.
// - writing one clears the change flag; writing zero is ignored.
// - status bit is read-only; writes have no effect.
// - shutdown while regulator enable low; otherwise full or reduced.
// - reduced power while in stop mode, full performance otherwise.
package rsc_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] RSC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] RSC_IRQ_ST_OFS = 12'h004;
  localparam logic [11:0] RSC_IRQ_EN_OFS = 12'h008;
  localparam logic [11:0] RSC_IRQ_CL_OFS = 12'h00C;
  localparam logic [11:0] RSC_MODE_OFS   = 12'h010;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int RSC_CHG_BIT = 0;
  localparam int RSC_IE_BIT  = 1;
  localparam int RSC_LVS_BIT = 2;
  localparam int RSC_PWR_BIT = 1;
  localparam int RSC_LVR_BIT = 2;
  localparam int RSC_NIRQ    = 3;

  localparam logic [31:0] RSC_ZERO32 = 32'h0000_0000;
  localparam logic [RSC_NIRQ-1:0] RSC_IRQ_RST = 3'h0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    RSC_FULL   = 3'b001,
    RSC_REDUCE = 3'b010,
    RSC_SHUT   = 3'b100
  } rsc_mode_e;

  typedef struct packed {
    logic lv_cmp;
    logic por_cmp;
    logic lvr_cmp;
  } rsc_cmp_s;

endpackage : rsc_pkg

//--- rtl/rsc_sync.sv
// two-flop synchroniser for comparator levels
`timescale 1ns/1ps
module rsc_sync #(
  parameter int W = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) $error("rsc_sync width must be positive");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : rsc_sync

//--- rtl/rsc_top.sv
// regulator supervisor control: mode, detector, resets, irq, apb regs
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        regulator_enable_input,
  input  wire logic        stop_mode,
  input  wire rsc_cmp_s    cmp,
  output logic             low_voltage_irq,
  output logic             irq,
  output logic             por_signal,
  output logic             low_voltage_reset_signal,
  output logic             amp_bandgap_en,
  output logic             detector_en,
  output logic             full_performance_mode,
  output logic             reduced_power_mode,
  output logic             shutdown_mode
);

  // ************************************************************
  // helper functions
  // ************************************************************
  // true when a mode code selects the wanted operating mode
  function automatic logic mode_is(input rsc_mode_e m,
                                   input rsc_mode_e want);
    return (m == want);
  endfunction : mode_is

  // full address match against one register offset
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] ofs);
    return (a == ofs);
  endfunction : addr_hit

  // ************************************************************
  // comparator synchronisation
  // ************************************************************
  rsc_cmp_s cmp_s;
  logic [2:0] cmp_sync;

  // the power-on comparator travels inverted through the synchroniser:
  // its flops clear to zero, which must read as supply below threshold,
  // else a false power-on release would follow every reset
  rsc_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({cmp.lv_cmp, ~cmp.por_cmp, cmp.lvr_cmp}),
    .q       (cmp_sync)
  );
  assign cmp_s.lv_cmp  = cmp_sync[2];
  assign cmp_s.por_cmp = ~cmp_sync[1];
  assign cmp_s.lvr_cmp = cmp_sync[0];

  // ************************************************************
  // mode control
  // ************************************************************
  rsc_mode_e mode_d;
  rsc_mode_e mode_q;

  assign mode_d = !regulator_enable_input ? RSC_SHUT :
                  stop_mode ? RSC_REDUCE : RSC_FULL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= RSC_SHUT;
    else          mode_q <= mode_d;
  end

  // mode seen by the detector and reset gating, one cycle behind pins
  wire is_full = mode_is(mode_q, RSC_FULL);

  // ************************************************************
  // apb decode
  // ************************************************************
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire hit_ctl = addr_hit(paddr, RSC_CTRL_OFS);
  wire hit_st  = addr_hit(paddr, RSC_IRQ_ST_OFS);
  wire hit_en  = addr_hit(paddr, RSC_IRQ_EN_OFS);
  wire hit_cl  = addr_hit(paddr, RSC_IRQ_CL_OFS);
  wire hit_md  = addr_hit(paddr, RSC_MODE_OFS);
  wire mapped  = hit_ctl | hit_st | hit_en | hit_cl | hit_md;
  // only the lowest byte lane carries writable bits
  wire lane0   = pstrb[0];

  // write strobes per register; the write lands at every access
  // edge, which is harmless as all writable fields are idempotent
  wire wr_ctl  = wr & hit_ctl & lane0;
  wire wr_en   = wr & hit_en & lane0;
  wire wr_cl   = wr & hit_cl & lane0;

  // ************************************************************
  // low-voltage detector
  // ************************************************************
  logic lvs_q;
  logic lvs_d;
  logic chg_q;
  logic chg_d;
  logic ie_q;
  logic ie_d;

  // status is zero outside full mode; cmp high means below threshold,
  // hysteresis lives in the analog comparator
  assign lvs_d = is_full & cmp_s.lv_cmp;
  wire lvs_edge = (lvs_d != lvs_q);
  // a zero written to the flag bit leaves it alone
  wire chg_clr  = wr_ctl & pwdata[RSC_CHG_BIT];
  // set wins over clear; mode entry never clears
  assign chg_d = lvs_edge | (chg_q & ~chg_clr);
  assign ie_d  = wr_ctl ? pwdata[RSC_IE_BIT] : ie_q;

  // status: no write path reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lvs_q <= 1'b0;
    else          lvs_q <= lvs_d;
  end

  // sticky change flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) chg_q <= 1'b0;
    else          chg_q <= chg_d;
  end

  // interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ie_q <= 1'b0;
    else          ie_q <= ie_d;
  end

  // ************************************************************
  // resets
  // ************************************************************
  logic por_d;
  logic lvr_d;
  // por comparator high means core supply below power-on threshold
  assign por_d = cmp_s.por_cmp;
  assign lvr_d = is_full & cmp_s.lvr_cmp;

  // ************************************************************
  // interrupt status / enable / clear
  // ************************************************************
  logic [RSC_NIRQ-1:0] ist_q;
  logic [RSC_NIRQ-1:0] ist_d;
  logic [RSC_NIRQ-1:0] ien_q;
  logic [RSC_NIRQ-1:0] ien_d;
  logic [RSC_NIRQ-1:0] iev;
  logic [RSC_NIRQ-1:0] icl;
  logic                por_q;
  logic                lvr_q;

  assign iev[RSC_CHG_BIT] = lvs_edge;
  assign iev[RSC_PWR_BIT] = por_q & ~por_d;
  assign iev[RSC_LVR_BIT] = lvr_d & ~lvr_q;
  assign icl   = wr_cl ? pwdata[RSC_NIRQ-1:0] : RSC_IRQ_RST;
  // an event in the cycle of its clear keeps the bit set
  assign ist_d = iev | (ist_q & ~icl);
  assign ien_d = wr_en ? pwdata[RSC_NIRQ-1:0] : ien_q;

  // sticky status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ist_q <= RSC_IRQ_RST;
    else          ist_q <= ist_d;
  end

  // enable mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ien_q <= RSC_IRQ_RST;
    else          ien_q <= ien_d;
  end

  // ************************************************************
  // read mux
  // ************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RSC_ZERO32;
    case (1'b1)
      hit_ctl: begin
        rd_mux[RSC_CHG_BIT] = chg_q;
        rd_mux[RSC_IE_BIT]  = ie_q;
        rd_mux[RSC_LVS_BIT] = lvs_q;
      end
      hit_st: rd_mux[RSC_NIRQ-1:0] = ist_q;
      hit_en: rd_mux[RSC_NIRQ-1:0] = ien_q;
      hit_md: rd_mux[2:0] = mode_q;
      default: rd_mux = RSC_ZERO32;
    endcase
  end

  // ************************************************************
  // next values of the registered outputs
  // ************************************************************
  // one wait state: ready in the cycle after penable first rises
  wire apb_first   = acc & ~pready;
  wire apb_rd      = psel & ~pwrite;
  // level requests follow the next flag state, no extra cycle
  wire lvirq_d     = chg_d & ie_d;
  wire irq_any_d   = |(ist_d & ien_d);
  // mode view is taken from the next mode so pins and view agree
  wire next_full   = mode_is(mode_d, RSC_FULL);
  wire next_reduce = mode_is(mode_d, RSC_REDUCE);
  wire next_shut   = mode_is(mode_d, RSC_SHUT);

  // ************************************************************
  // apb response
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= RSC_ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_first;
      pslverr <= apb_first & ~mapped;
      prdata  <= apb_rd ? rd_mux : RSC_ZERO32;
    end
  end

  // ************************************************************
  // interrupt outputs
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_voltage_irq <= 1'b0;
      irq             <= 1'b0;
    end else begin
      low_voltage_irq <= lvirq_d;
      irq             <= irq_any_d;
    end
  end

  // ************************************************************
  // reset outputs
  // ************************************************************
  // power-on reset starts high: the core is held until the supply
  // has been seen above threshold through the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_q <= 1'b1;
      lvr_q <= 1'b0;
    end else begin
      por_q <= por_d;
      lvr_q <= lvr_d;
    end
  end

  // ************************************************************
  // mode view and analog enables
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_bandgap_en        <= 1'b0;
      detector_en           <= 1'b0;
      full_performance_mode <= 1'b0;
      reduced_power_mode    <= 1'b0;
      shutdown_mode         <= 1'b1;
    end else begin
      amp_bandgap_en        <= next_full;
      detector_en           <= next_full;
      full_performance_mode <= next_full;
      reduced_power_mode    <= next_reduce;
      shutdown_mode         <= next_shut;
    end
  end

  assign por_signal               = por_q;
  assign low_voltage_reset_signal = lvr_q;

endmodule : rsc_top

//--- test/rsc_props.sv
// checker: port-level properties of the supervisor block
`timescale 1ns/1ps
module rsc_props
  import rsc_pkg::*;
(
  input wire logic     pclk,
  input wire logic     presetn,
  input wire logic     psel,
  input wire logic     penable,
  input wire logic     pready,
  input wire logic     regulator_enable_input,
  input wire logic     stop_mode,
  input wire rsc_cmp_s cmp,
  input wire logic     por_signal,
  input wire logic     low_voltage_reset_signal,
  input wire logic     amp_bandgap_en,
  input wire logic     full_performance_mode,
  input wire logic     reduced_power_mode,
  input wire logic     shutdown_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable && !pready; endsequence
  sequence s_por_calm; $stable(cmp.por_cmp) [*5]; endsequence
  a_ready_wait: assert property (s_acc |=> pready)
    else $error("pready missing after access");
  a_ready_idle: assert property (!(psel && penable) |=> !pready)
    else $error("pready without access");
  a_por_track: assert property (
    s_por_calm |-> por_signal == cmp.por_cmp)
    else $error("power-on reset not tracking");
  a_lvr_gate: assert property (
    !full_performance_mode [*4] |-> !low_voltage_reset_signal)
    else $error("low-voltage reset outside full mode");
  a_mode_shut: assert property (
    !regulator_enable_input |=> shutdown_mode)
    else $error("shutdown not entered");
  a_mode_red: assert property (
    regulator_enable_input && stop_mode |=> reduced_power_mode)
    else $error("reduced mode not entered");
  a_mode_full: assert property (
    regulator_enable_input && !stop_mode |=> full_performance_mode)
    else $error("full mode not entered");
  a_amp_full: assert property (
    amp_bandgap_en == full_performance_mode)
    else $error("amplifier enable wrong");
  a_mode_hot: assert property ($onehot({full_performance_mode,
    reduced_power_mode, shutdown_mode}))
    else $error("mode view not one-hot");
endmodule : rsc_props

//--- test/rsc_rstgen.sv
// partner model: chip reset generator holding blocks during resets
`timescale 1ns/1ps
module rsc_rstgen (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic por_signal,
  input  wire logic lv_rst,
  output logic      blk_rst_n
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) blk_rst_n <= 1'b0;
    else blk_rst_n <= !(por_signal || lv_rst);
  end
endmodule : rsc_rstgen

//--- test/tb_top.sv
// testbench: supervisor modes, resets, detector flags and irq regs
`timescale 1ns/1ps
module tb_top
  import rsc_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        reg_en = 1, stop = 0, pready, pslverr, er, blk_n;
  logic        o_lvirq, o_irq, o_por, o_lvrst, o_amp, o_det;
  logic        o_full, o_red, o_shut;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, seed = 32'h0001_17CB;
  rsc_cmp_s    cmp = 3'b010;
  int          errors = 0, cmp_count = 0, m_ctrl = 0, m_st = 0;
  rsc_top u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'h1), .prdata, .pready, .pslverr, .cmp,
    .regulator_enable_input(reg_en), .stop_mode(stop),
    .low_voltage_irq(o_lvirq), .irq(o_irq), .por_signal(o_por),
    .low_voltage_reset_signal(o_lvrst), .amp_bandgap_en(o_amp),
    .detector_en(o_det), .full_performance_mode(o_full),
    .reduced_power_mode(o_red), .shutdown_mode(o_shut)
  );
  rsc_rstgen u_rgen (.pclk, .presetn, .por_signal(o_por),
    .lv_rst(o_lvrst), .blk_rst_n(blk_n));
  initial begin
    forever #25 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic final_report();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk32
  task automatic chk1(input logic g, input logic e);
    chk32({31'h0, g}, {31'h0, e});
  endtask : chk1
  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      final_report();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cyc(2);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk32(rd, e);
  endtask : rchk
  initial begin
    cyc(12);
    presetn <= 1'b1;
    cyc(2);
    chk1(o_por, 1'b1);
    cyc(3);
    chk1(blk_n, 1'b0);
    cmp.por_cmp <= 1'b0;
    cyc(5);
    chk1(o_por, 1'b0);
    chk1(blk_n, 1'b1);
    m_st = 2;
    for (int i = 0; i < 3; i++) begin
      reg_en <= (i != 2);
      stop <= (i == 1);
      cyc(3);
      rchk(RSC_MODE_OFS, 32'(1 << i));
      chk1(o_det, i == 0);
      chk1(o_amp, i == 0);
      chk32({o_shut, o_red, o_full}, 32'(1 << i));
      cmp.por_cmp <= 1'b1;
      cyc(5);
      chk1(o_por, 1'b1);
      cmp.por_cmp <= 1'b0;
      cyc(5);
    end
    reg_en <= 1'b1;
    stop <= 1'b0;
    cyc(3);
    rchk(RSC_IRQ_ST_OFS, 32'(m_st));
    chk1(er, 1'b0);
    wr(RSC_IRQ_CL_OFS, 32'h7);
    cmp.lv_cmp <= 1'b1;
    cyc(5);
    m_ctrl = 5;
    rchk(RSC_CTRL_OFS, 32'(m_ctrl));
    wr(RSC_CTRL_OFS, 32'h6);
    m_ctrl = 7;
    rchk(RSC_CTRL_OFS, 32'(m_ctrl));
    chk1(o_lvirq, 1'b1);
    wr(RSC_CTRL_OFS, 32'h3);
    m_ctrl = 6;
    rchk(RSC_CTRL_OFS, 32'(m_ctrl));
    chk1(o_lvirq, 1'b0);
    wr(RSC_CTRL_OFS, 32'h0);
    cmp.lv_cmp <= 1'b0;
    cyc(5);
    m_ctrl = 1;
    rchk(RSC_CTRL_OFS, 32'(m_ctrl));
    chk1(o_lvirq, 1'b0);
    stop <= 1'b1;
    cyc(3);
    rchk(RSC_CTRL_OFS, 32'(m_ctrl));
    cmp.lv_cmp <= 1'b1;
    cyc(5);
    rchk(RSC_CTRL_OFS, 32'(m_ctrl));
    cmp.lv_cmp <= 1'b0;
    cyc(5);
    stop <= 1'b0;
    cyc(3);
    wr(RSC_IRQ_CL_OFS, 32'h7);
    wr(RSC_IRQ_EN_OFS, 32'h4);
    cmp.lvr_cmp <= 1'b1;
    cyc(6);
    m_st = 4;
    chk1(o_lvrst, 1'b1);
    chk1(o_irq, 1'b1);
    rchk(RSC_IRQ_ST_OFS, 32'(m_st));
    wr(RSC_IRQ_EN_OFS, 32'h0);
    chk1(o_irq, 1'b0);
    wr(RSC_IRQ_EN_OFS, 32'h4);
    chk1(o_irq, 1'b1);
    wr(RSC_IRQ_CL_OFS, 32'h4);
    chk1(o_irq, 1'b0);
    stop <= 1'b1;
    cyc(4);
    chk1(o_lvrst, 1'b0);
    cmp.lvr_cmp <= 1'b0;
    cyc(5);
    stop <= 1'b0;
    rchk(12'h020, 32'h0);
    chk1(er, 1'b1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(RSC_IRQ_EN_OFS, seed);
      rchk(RSC_IRQ_EN_OFS, seed & 32'h7);
    end
    final_report();
  end
endmodule : tb_top
bind rsc_top rsc_props u_props (.pclk, .presetn, .psel, .penable,
  .pready, .regulator_enable_input, .stop_mode, .cmp, .por_signal,
  .low_voltage_reset_signal, .amp_bandgap_en, .full_performance_mode,
  .reduced_power_mode, .shutdown_mode);
